// >>> logic/reload_timer_map.vh
// Constants for the dual reload down timer: register indices, field positions, resets.
// Assumes a Wishbone classic slave with 32-bit data; byte address is four times the index.
// Functional notes
// - Two independent 32-bit down counters, each with its own start value and enable bit; the prescaler is shared.
// - Enabling a timer loads its counter from the start value, then it counts down once per tick.
// - Counting down past zero raises that timer's interrupt and reloads from the start value.
// - The count, underflow and reload loop repeats while the enable bit stays set.
// - Enable register bit 1 runs timer one and bit 0 runs timer zero; one means enabled.
// - Prescaler setting c in configuration bits 7:0 divides the clock by c plus one.
// - A start value c gives one interrupt every c plus one ticks.
// - The 32-bit start value is kept and used for every reload.
// - Reading the counter halves returns the live count.
// - Writing the counter halves replaces the live count for one different interval.
// - Each timer has its own interrupt request raised at its underflow.
// - Timer zero start value halves sit at 0xC034 and 0xC035, read/write, reset zero.
// - Timer zero counter halves sit at 0xC036 and 0xC037, read/write, reset zero.
// - Timer one uses 0xC038/0xC039 for start value and 0xC03A/0xC03B for counter.
`ifndef RELOAD_TIMER_MAP_VH
`define RELOAD_TIMER_MAP_VH

// ============================================================
// Register indices (byte address = index * 4)
`define REG_PRESCALE_CONFIG 16'hc030
`define REG_ENABLE_BITS 16'hc031
`define REG_T0_RELOAD_LOW 16'hc034
`define REG_T0_RELOAD_HIGH 16'hc035
`define REG_T0_COUNT_LOW 16'hc036
`define REG_T0_COUNT_HIGH 16'hc037
`define REG_T1_RELOAD_LOW 16'hc038
`define REG_T1_RELOAD_HIGH 16'hc039
`define REG_T1_COUNT_LOW 16'hc03a
`define REG_T1_COUNT_HIGH 16'hc03b
`define REG_IRQ_STATUS 16'hc03c
`define REG_IRQ_MASK 16'hc03d

// ============================================================
// Fields and resets
`define PRESCALE_MSB 7
`define EN_T0_BIT 0
`define EN_T1_BIT 1
`define PRESCALE_RESET 8'h00
`define ENABLE_RESET 2'h0
`define HALF_RESET 16'h0000
`define IRQ_RESET 2'h0

`endif

// >>> logic/dual_reload_down_timer.v
// Two 32-bit auto-reload down counters behind one shared clock prescaler.
// Assumes a classic Wishbone master with 32-bit data on the same clock.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`include "reload_timer_map.vh"

module dual_reload_down_timer #(
    parameter ADDR_W = 18
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [ADDR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Interrupts
    output wire timer0_irq_o,
    output wire timer1_irq_o,
    output wire irq_o
);

    // ============================================================
    // Register state
    reg [7:0] tick_prescale_value_ff;
    reg [7:0] nxt_tick_prescale_value;
    reg [1:0] run_control_bits_ff;
    reg [1:0] nxt_run_control_bits;
    reg [1:0] irq_mask_ff;
    reg [1:0] nxt_irq_mask;
    reg [1:0] irq_status_ff;
    reg [1:0] nxt_irq_status;
    reg [7:0] prescale_cnt_ff;
    reg [7:0] nxt_prescale_cnt;
    reg tick_ff;
    reg nxt_tick;
    reg [31:0] reload_value_pair0_ff;
    reg [31:0] nxt_reload_value_pair0;
    reg [31:0] reload_value_pair1_ff;
    reg [31:0] nxt_reload_value_pair1;
    reg [31:0] live_count0_ff;
    reg [31:0] nxt_live_count0;
    reg [31:0] live_count1_ff;
    reg [31:0] nxt_live_count1;
    reg [1:0] run_prev_ff;
    reg [1:0] underflow_ff;
    reg [31:0] nxt_dat;
    reg nxt_ack;

    // ============================================================
    // Helpers
    // Byte-lane merge for one 16-bit half; lanes 2 and 3 have no storage
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
        end
    endfunction

    // Register index compare
    function hit;
        input [15:0] idx;
        input [15:0] reg_addr;
        begin
            hit = (idx == reg_addr);
        end
    endfunction

    // Zero test of a live count
    function is_zero;
        input [31:0] count;
        begin
            is_zero = (count == 32'h00000000);
        end
    endfunction

    // Next start value of one timer; halves are written on their own, no latching
    function [31:0] next_reload;
        input [31:0] reload;
        input wr_lo;
        input wr_hi;
        input [31:0] dat;
        input [3:0] sel;
        begin
            next_reload = reload;
            if (wr_lo)
                next_reload[15:0] = merge16(reload[15:0], dat, sel);
            if (wr_hi)
                next_reload[31:16] = merge16(reload[31:16], dat, sel);
        end
    endfunction

    // Next live count of one timer; a bus write wins over load and count
    function [31:0] next_count;
        input [31:0] count;
        input [31:0] reload;
        input wr_lo;
        input wr_hi;
        input start;
        input under;
        input step;
        input [31:0] dat;
        input [3:0] sel;
        begin
            if (wr_lo)
                next_count = {count[31:16], merge16(count[15:0], dat, sel)};
            else if (wr_hi)
                next_count = {merge16(count[31:16], dat, sel), count[15:0]};
            else if (start)
                next_count = reload;
            else if (under)
                next_count = reload;
            else if (step)
                next_count = count - 32'h00000001;
            else
                next_count = count;
        end
    endfunction

    // ============================================================
    // Bus decode
    // Index is the word address; the two low address bits are ignored
    wire [15:0] reg_idx = adr_i[17:2];
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire wr_lane0 = wr & sel_i[0];
    wire hit_prescale = hit(reg_idx, `REG_PRESCALE_CONFIG);
    wire hit_enable = hit(reg_idx, `REG_ENABLE_BITS);
    wire hit_status = hit(reg_idx, `REG_IRQ_STATUS);
    wire hit_mask = hit(reg_idx, `REG_IRQ_MASK);
    wire hit_rl0_lo = hit(reg_idx, `REG_T0_RELOAD_LOW);
    wire hit_rl0_hi = hit(reg_idx, `REG_T0_RELOAD_HIGH);
    wire hit_ct0_lo = hit(reg_idx, `REG_T0_COUNT_LOW);
    wire hit_ct0_hi = hit(reg_idx, `REG_T0_COUNT_HIGH);
    wire hit_rl1_lo = hit(reg_idx, `REG_T1_RELOAD_LOW);
    wire hit_rl1_hi = hit(reg_idx, `REG_T1_RELOAD_HIGH);
    wire hit_ct1_lo = hit(reg_idx, `REG_T1_COUNT_LOW);
    wire hit_ct1_hi = hit(reg_idx, `REG_T1_COUNT_HIGH);

    // ============================================================
    // Timer events
    wire run0 = run_control_bits_ff[`EN_T0_BIT];
    wire run1 = run_control_bits_ff[`EN_T1_BIT];
    // A rising enable bit loads the start value before the first tick
    wire start0 = run0 & ~run_prev_ff[0];
    wire start1 = run1 & ~run_prev_ff[1];
    // A tick that finds zero takes the count below zero
    wire underflow0 = run0 & ~start0 & tick_ff & is_zero(live_count0_ff);
    wire underflow1 = run1 & ~start1 & tick_ff & is_zero(live_count1_ff);
    wire [1:0] underflow = {underflow1, underflow0};
    // Clearing the enable bit freezes the count where it stands
    wire step0 = run0 & tick_ff;
    wire step1 = run1 & tick_ff;

    // ============================================================
    // Bus slave: ack one cycle after the request, read data with it
    always @* begin
        nxt_ack = req;
        nxt_dat = dat_o;
        if (req) begin
            case (reg_idx)
                `REG_PRESCALE_CONFIG: nxt_dat = {24'h000000, tick_prescale_value_ff};
                `REG_ENABLE_BITS: nxt_dat = {30'h0, run_control_bits_ff};
                `REG_T0_RELOAD_LOW: nxt_dat = {16'h0000, reload_value_pair0_ff[15:0]};
                `REG_T0_RELOAD_HIGH: nxt_dat = {16'h0000, reload_value_pair0_ff[31:16]};
                `REG_T0_COUNT_LOW: nxt_dat = {16'h0000, live_count0_ff[15:0]};
                `REG_T0_COUNT_HIGH: nxt_dat = {16'h0000, live_count0_ff[31:16]};
                `REG_T1_RELOAD_LOW: nxt_dat = {16'h0000, reload_value_pair1_ff[15:0]};
                `REG_T1_RELOAD_HIGH: nxt_dat = {16'h0000, reload_value_pair1_ff[31:16]};
                `REG_T1_COUNT_LOW: nxt_dat = {16'h0000, live_count1_ff[15:0]};
                `REG_T1_COUNT_HIGH: nxt_dat = {16'h0000, live_count1_ff[31:16]};
                `REG_IRQ_STATUS: nxt_dat = {30'h0, irq_status_ff};
                `REG_IRQ_MASK: nxt_dat = {30'h0, irq_mask_ff};
                // Unmapped indices read as zero and are still answered
                default: nxt_dat = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= nxt_ack;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else begin
            dat_o <= nxt_dat;
        end
    end

    // ============================================================
    // Control registers; only byte lane 0 holds bits
    always @* begin
        nxt_tick_prescale_value = tick_prescale_value_ff;
        nxt_run_control_bits = run_control_bits_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_lane0 & hit_prescale)
            nxt_tick_prescale_value = dat_i[`PRESCALE_MSB:0];
        if (wr_lane0 & hit_enable)
            nxt_run_control_bits = dat_i[1:0];
        if (wr_lane0 & hit_mask)
            nxt_irq_mask = dat_i[1:0];
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_prescale_value_ff <= `PRESCALE_RESET;
        end else begin
            tick_prescale_value_ff <= nxt_tick_prescale_value;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            run_control_bits_ff <= `ENABLE_RESET;
        end else begin
            run_control_bits_ff <= nxt_run_control_bits;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= `IRQ_RESET;
        end else begin
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // ============================================================
    // Shared prescaler: one tick every c+1 clocks for both timers
    // A setting lowered below the running count ends the period at once
    always @* begin
        if (prescale_cnt_ff >= tick_prescale_value_ff) begin
            nxt_prescale_cnt = 8'h00;
            nxt_tick = 1'b1;
        end else begin
            nxt_prescale_cnt = prescale_cnt_ff + 8'h01;
            nxt_tick = 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            prescale_cnt_ff <= 8'h00;
        end else begin
            prescale_cnt_ff <= nxt_prescale_cnt;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    // ============================================================
    // Timer zero
    // A count write in the cycle of an underflow still raises the interrupt
    wire wr_rl0_lo = wr & hit_rl0_lo;
    wire wr_rl0_hi = wr & hit_rl0_hi;
    wire wr_ct0_lo = wr & hit_ct0_lo;
    wire wr_ct0_hi = wr & hit_ct0_hi;

    always @* begin
        nxt_reload_value_pair0 = next_reload(reload_value_pair0_ff, wr_rl0_lo, wr_rl0_hi,
            dat_i, sel_i);
        nxt_live_count0 = next_count(live_count0_ff, reload_value_pair0_ff, wr_ct0_lo,
            wr_ct0_hi, start0, underflow0, step0, dat_i, sel_i);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            reload_value_pair0_ff <= {`HALF_RESET, `HALF_RESET};
        end else begin
            reload_value_pair0_ff <= nxt_reload_value_pair0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            live_count0_ff <= {`HALF_RESET, `HALF_RESET};
        end else begin
            live_count0_ff <= nxt_live_count0;
        end
    end

    // ============================================================
    // Timer one
    // Same layout as timer zero, separate registers so neither disturbs the other
    wire wr_rl1_lo = wr & hit_rl1_lo;
    wire wr_rl1_hi = wr & hit_rl1_hi;
    wire wr_ct1_lo = wr & hit_ct1_lo;
    wire wr_ct1_hi = wr & hit_ct1_hi;

    always @* begin
        nxt_reload_value_pair1 = next_reload(reload_value_pair1_ff, wr_rl1_lo, wr_rl1_hi,
            dat_i, sel_i);
        nxt_live_count1 = next_count(live_count1_ff, reload_value_pair1_ff, wr_ct1_lo,
            wr_ct1_hi, start1, underflow1, step1, dat_i, sel_i);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            reload_value_pair1_ff <= {`HALF_RESET, `HALF_RESET};
        end else begin
            reload_value_pair1_ff <= nxt_reload_value_pair1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            live_count1_ff <= {`HALF_RESET, `HALF_RESET};
        end else begin
            live_count1_ff <= nxt_live_count1;
        end
    end

    // ============================================================
    // Enable history and interrupt pulses of both timers
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_prev_ff <= 2'h0;
        end else begin
            run_prev_ff <= {run1, run0};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            underflow_ff <= 2'h0;
        end else begin
            underflow_ff <= underflow;
        end
    end

    // ============================================================
    // Sticky status, write one to clear; a new event wins over the clear
    // Bit 0 belongs to timer zero, bit 1 to timer one
    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_lane0 & hit_status)
            nxt_irq_status = irq_status_ff & ~dat_i[1:0];
        nxt_irq_status = nxt_irq_status | underflow;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_ff <= `IRQ_RESET;
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    // ============================================================
    // Interrupt outputs
    // Per-timer lines are one-clock pulses; the combined line is a level
    assign timer0_irq_o = underflow_ff[0];
    assign timer1_irq_o = underflow_ff[1];
    assign irq_o = |(irq_status_ff & irq_mask_ff);

endmodule

// >>> test/wb_host_model.sv
// Processor stand-in: classic Wishbone master, one request at a time.
// Assumes a slave on the same clock that answers each request with ack.
`timescale 1ns/100ps
module wb_host_model (
    // Clock
    input wire clk_i,
    // Wishbone master
    output reg cyc_o, output reg stb_o, output reg we_o, output reg [17:0] adr_o,
    output reg [3:0] sel_o, output reg [31:0] dat_o, input wire [31:0] dat_i, input wire ack_i
);
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = 57'h0;
    // ==========
    // Released lines show the inverse so stale data never passes for fresh
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'h3, w, 4'hf, a, 2'h0, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'h0, ~adr_o, ~dat_o};
    endtask
endmodule

// >>> test/timer_props.sv
// Port checker for the dual reload down timer, bound to its top module.
// Assumes a master that holds each request until it sees ack.
`timescale 1ns/100ps
`include "reload_timer_map.vh"
module timer_props #(parameter ADDR_W = 18) (
    input wire clk_i, input wire rst_i, input wire cyc_i, input wire stb_i, input wire we_i,
    input wire [ADDR_W-1:0] adr_i, input wire [31:0] dat_o, input wire ack_o, input wire irq_o
);
    wire [15:0] idx = adr_i[17:2];
    wire rd = ack_o && !we_i;
    // ==========
    // Bus timing, unused bits read as zero, line drops only on a write
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack long");
    property p_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_cause: assert property (p_cause) else $error("stray ack");
    property p_hole; rd && (idx == 16'hc032 || idx == 16'hc033) |-> dat_o == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("hole data");
    property p_half; rd && idx >= `REG_T0_RELOAD_LOW && idx <= `REG_T1_COUNT_HIGH
        |-> dat_o[31:16] == 16'h0; endproperty
    a_half: assert property (p_half) else $error("half width");
    property p_cfg; rd && idx == `REG_PRESCALE_CONFIG |-> dat_o[31:8] == 24'h0; endproperty
    a_cfg: assert property (p_cfg) else $error("config width");
    property p_en; rd && idx == `REG_ENABLE_BITS |-> dat_o[31:2] == 30'h0; endproperty
    a_en: assert property (p_en) else $error("enable width");
    property p_fall; $fell(irq_o) |-> ack_o && we_i; endproperty
    a_fall: assert property (p_fall) else $error("irq fell");
endmodule
bind dual_reload_down_timer timer_props #(.ADDR_W(ADDR_W)) chk (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .irq_o);

// >>> test/dual_reload_down_timer_tb.sv
// Bench for the dual reload down timer; a bus model stands in for the processor.
// Assumes wb_host_model on the slave port and the bound port checker.
`timescale 1ns/100ps
`include "reload_timer_map.vh"
module dual_reload_down_timer_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    wire cyc_i, stb_i, we_i, ack_o, timer0_irq_o, timer1_irq_o, irq_o;
    wire [17:0] adr_i;
    wire [3:0] sel_i;
    wire [31:0] dat_i, dat_o;
    int num_errors = 0, n_checks = 0, tick_n = 0, q0[$], q1[$], c, r, k, t;
    logic [31:0] rd, mdl[int];
    always #10 clk_i = ~clk_i;
    wb_host_model host (.clk_i, .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
        .sel_o(sel_i), .dat_o(dat_i), .dat_i(dat_o), .ack_i(ack_o));
    dual_reload_down_timer uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .timer0_irq_o, .timer1_irq_o, .irq_o);
    // ==========
    // Pulse log in cycle numbers; the ceiling ends a hung run
    always @(posedge clk_i) begin
        tick_n <= tick_n + 1;
        if (timer0_irq_o === 1'b1) q0.push_back(tick_n);
        if (timer1_irq_o === 1'b1) q1.push_back(tick_n);
        if (tick_n == 5000) begin
            num_errors++;
            stop_test;
        end
    end
    task chk(input logic [31:0] e, input logic [31:0] g, input string s);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // Model keeps only the implemented bits of each register
    task wr(input logic [15:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
        mdl[a] = d & (a == `REG_PRESCALE_CONFIG ? 32'hff : a == `REG_ENABLE_BITS ? 32'h3 :
            a == `REG_IRQ_MASK ? 32'h3 : 32'hffff);
    endtask
    task rdc(input logic [15:0] a);
        host.xfer(1'b0, a, 32'h0, rd);
        chk(mdl.exists(a) ? mdl[a] : 32'h0, rd, "register");
    endtask
    task stop_test;
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(85));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 'hc030; a < 'hc03e; a++) rdc(a[15:0]);
        for (int a = 'hc034; a < 'hc03c; a++) wr(a[15:0], $urandom);
        host.xfer(1'b1, 16'hc032, $urandom, rd);
        for (int a = 'hc030; a < 'hc03c; a++) rdc(a[15:0]);
        // Timer zero alone, masked at first: status sets, line stays low
        c = $urandom % 4;
        r = 1 + $urandom % 5;
        wr(`REG_PRESCALE_CONFIG, c);
        for (int a = 'hc034; a < 'hc03c; a += 4) wr(a[15:0], r);
        for (int a = 'hc035; a < 'hc03c; a += 4) wr(a[15:0], 0);
        wr(`REG_IRQ_MASK, 0);
        wr(`REG_ENABLE_BITS, 1);
        wait (q0.size() == 3);
        chk((r + 1) * (c + 1), q0[2] - q0[1], "period");
        chk(0, q1.size() + irq_o, "quiet");
        host.xfer(1'b0, `REG_IRQ_STATUS, 0, rd);
        chk(1, rd, "status");
        wr(`REG_IRQ_MASK, 1);
        chk(1, irq_o, "raised");
        wr(`REG_ENABLE_BITS, 0);
        host.xfer(1'b1, `REG_IRQ_STATUS, 1, rd);
        chk(0, irq_o, "cleared");
        // Timer one ticking every clock: load on enable, reload, one-shot count
        wr(`REG_PRESCALE_CONFIG, 0);
        wr(`REG_ENABLE_BITS, 2);
        t = tick_n;
        wait (q1.size() == 2);
        chk(r + 2, q1[0] - t, "load");
        chk(r + 1, q1[1] - q1[0], "reload");
        k = r + 3 + $urandom % 4;
        wr(`REG_T1_COUNT_LOW, k);
        t = tick_n;
        // A pulse from an underflow during the write is flushed with the queue
        @(posedge clk_i);
        q1.delete();
        wait (q1.size() == 2);
        chk(k + 1, q1[0] - t, "oneshot");
        chk(r + 1, q1[1] - q1[0], "resume");
        host.xfer(1'b0, `REG_IRQ_STATUS, 0, rd);
        chk(2, rd, "status1");
        stop_test;
    end
endmodule
